// *** design/asrp_pkg.sv ***
// Shared constants and types for the serial result port and its host
package asrp_pkg;
    // ---------------------------------------------------------------
    // Clock and frame
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int FRAME_BITS = 32;
    localparam logic [5:0] FRAME_LAST = 6'h1f;
    localparam logic [5:0] FRAME_FULL = 6'h20;
    localparam logic [5:0] BIT_FIRST = 6'h01;
    localparam logic [5:0] BIT_ZERO = 6'h00;

    // ---------------------------------------------------------------
    // Conversion timing
    // ---------------------------------------------------------------
    localparam int CONV_TIME_NS = 147_000_000;
    localparam int CONV_TICKS_DFLT = 20510;
    // Least conversion time, so the tick period rounds up
    localparam int INT_OSC_CYCLES_DFLT =
        (CONV_TIME_NS + CONV_TICKS_DFLT * CLK_PERIOD_NS - 1) /
        (CONV_TICKS_DFLT * CLK_PERIOD_NS);
    localparam int TEST_DLY_NS = 26_000;
    localparam int TEST_DLY_CYCLES =
        (TEST_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // 3.6 oscillator periods, rounded up to whole ticks
    localparam int TEST_DLY_TICKS = 4;
    // Serial clock is the conversion clock divided by 8
    localparam logic [1:0] SCK_HALF_LAST = 2'h3;
    localparam logic [10:0] OSC_LOST_LAST = 11'h7ff;

    // ---------------------------------------------------------------
    // Host timing
    // ---------------------------------------------------------------
    localparam logic [3:0] HOST_HALF_LAST = 4'h7;
    localparam logic [3:0] HOST_SETTLE_LAST = 4'h3;

    // ---------------------------------------------------------------
    // State encodings
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ASRP_CONV = 2'b00,
        ASRP_SLEEP = 2'b01,
        ASRP_OUT = 2'b11
    } asrp_state_t;

    typedef enum logic [1:0] {
        ASRP_H_IDLE = 2'b00,
        ASRP_H_WAIT = 2'b01,
        ASRP_H_CLK = 2'b11,
        ASRP_H_DONE = 2'b10
    } asrp_hstate_t;
endpackage : asrp_pkg

// *** design/asrp_if.sv ***
// Three-wire link between the converter port and its host
`timescale 1ns/1ps
interface asrp_if;
    logic cs_n;
    logic host_sck_o;
    logic host_sck_oe_n;
    logic dev_sck_o;
    logic dev_sck_oe_n;
    logic dev_sck_pu;
    logic dev_sdo_o;
    logic dev_sdo_oe_n;
    logic sck;
    logic sdo;

    // Wire levels; a released line with pull-up off is kept low
    assign sck = !dev_sck_oe_n ? dev_sck_o :
                 !host_sck_oe_n ? host_sck_o : dev_sck_pu;
    // Released data line reads high
    assign sdo = !dev_sdo_oe_n ? dev_sdo_o : 1'b1;

    modport dev (
        input cs_n,
        input sck,
        output dev_sck_o,
        output dev_sck_oe_n,
        output dev_sck_pu,
        output dev_sdo_o,
        output dev_sdo_oe_n
    );

    modport host (
        output cs_n,
        output host_sck_o,
        output host_sck_oe_n,
        input sck,
        input sdo
    );
endinterface : asrp_if

// *** design/asrp_dev.sv ***
// Converter end: conversion cycle, status and 32-bit result shift
`timescale 1ns/1ps
// Summary of operation
// - Chip select fall picks clock mode
// - Data line shows busy flag when selected
// - Conversion end enters sleep unconditionally
// - Sleep holds result in shift register
// - First clock rise in sleep starts output
// - Data changes on falls, sampled on rises
// - Frame is 32 bits, flag first
// - External: 32nd fall restarts, data high
// - External: select rise aborts and restarts
// - Mode latched at reset release
// - Internal: clock pull-up on during select fall
// - Internal: select low drives clock low
// - Internal: output after status test delay
// - Early select rise keeps device asleep
// - Internal: after 32nd rise, restart
// - Internal: select rise aborts and restarts
// - Pull-up off whenever clock is low, except at a status-test select rise
// - Select rise in status test rearms pull-up
// - Result loaded at busy flag fall
// - Host may watch flag or release
// - Internal clock is conversion clock over 8
// - Internal conversion lasts 147 ms
module asrp_dev
    import asrp_pkg::*;
#(
    parameter int CONV_TICKS = CONV_TICKS_DFLT,
    parameter int INT_OSC_CYCLES = INT_OSC_CYCLES_DFLT
) (
    input wire logic clk,
    input wire logic resetn,
    asrp_if.dev bus,
    input wire logic osc_source_pin,
    input wire logic [30:0] result_in,
    output logic conv_busy,
    output logic conv_start
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    asrp_state_t st_ff, nxt_st;
    logic cs_q_ff, sck_q_ff, osc_q_ff;
    logic ext_mode_ff, nxt_ext_mode, por_done_ff;
    logic osc_ext_ff;
    logic [10:0] lost_ff;
    logic [9:0] div_ff;
    logic [14:0] conv_cnt_ff;
    logic [11:0] dly_ff;
    logic [1:0] half_ff;
    logic [5:0] bcnt_ff, nxt_bcnt;
    logic [31:0] shift_ff, nxt_shift;
    logic sck_o_ff, nxt_sck_o;
    logic sck_oe_n_ff, sck_pu_ff, sdo_o_ff, sdo_oe_n_ff;
    logic busy_ff, start_ff;

    // ---------------------------------------------------------------
    // Edge decode of the pins and the conversion clock
    // ---------------------------------------------------------------
    wire cs_fall = cs_q_ff & ~bus.cs_n;
    wire cs_rise = ~cs_q_ff & bus.cs_n;
    wire pin_rise = ~sck_q_ff & bus.sck;
    wire pin_fall = sck_q_ff & ~bus.sck;
    wire osc_rise = ~osc_q_ff & osc_source_pin;
    wire div_wrap = div_ff == 10'(INT_OSC_CYCLES - 1);
    // Pin oscillator wins whenever it toggles
    wire tick = osc_ext_ff ? osc_rise : div_wrap;
    wire int_mode = ~ext_mode_ff;
    wire in_conv = st_ff == ASRP_CONV;
    wire in_sleep = st_ff == ASRP_SLEEP;
    wire in_out = st_ff == ASRP_OUT;

    // ---------------------------------------------------------------
    // Cycle decode
    // ---------------------------------------------------------------
    wire conv_end = in_conv & tick &
        (conv_cnt_ff == 15'(CONV_TICKS - 1));
    // Status test delay counts cycles, or ticks on the pin oscillator
    wire dly_step = osc_ext_ff ? tick : 1'b1;
    wire [11:0] dly_last = osc_ext_ff ? 12'(TEST_DLY_TICKS - 1)
                                      : 12'(TEST_DLY_CYCLES - 1);
    wire dly_run = int_mode & in_sleep & ~bus.cs_n & ~cs_fall;
    wire go_out_int = dly_run & dly_step & (dly_ff == dly_last);
    wire go_out_ext = ext_mode_ff & in_sleep & ~bus.cs_n &
        pin_rise;
    wire half_end = tick & (half_ff == SCK_HALF_LAST);
    wire abort = in_out & cs_rise;
    wire end_ext = ext_mode_ff & in_out & pin_fall &
        (bcnt_ff == FRAME_LAST);
    wire end_int = int_mode & in_out & half_end & sck_o_ff &
        (bcnt_ff == FRAME_FULL);
    wire to_conv = abort | end_ext | end_int;
    // Data moves only on a serial clock fall
    wire shift_now = in_out & ~to_conv &
        (ext_mode_ff ? pin_fall : half_end & sck_o_ff);
    wire rise_now = int_mode & in_out & half_end & ~sck_o_ff;
    // Pull-up rearmed when a status test is cut short
    wire pu_rearm = cs_rise & in_sleep & int_mode;

    // ---------------------------------------------------------------
    // Next state; select rise outside output is ignored here
    // ---------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        unique case (st_ff)
            ASRP_CONV:
            begin
                if (conv_end)
                    nxt_st = ASRP_SLEEP;
            end
            ASRP_SLEEP:
            begin
                if (go_out_ext | go_out_int)
                    nxt_st = ASRP_OUT;
            end
            ASRP_OUT:
            begin
                if (to_conv)
                    nxt_st = ASRP_CONV;
            end
            default:
                nxt_st = ASRP_CONV;
        endcase
    end

    // Clock mode: strap at reset release, then every select fall
    always_comb
    begin
        nxt_ext_mode = ext_mode_ff;
        if (!por_done_ff)
            nxt_ext_mode = ~bus.sck;
        else if (cs_fall)
            nxt_ext_mode = ~bus.sck;
    end

    // Shift register: load at busy fall, hold in sleep, shift on falls
    always_comb
    begin
        nxt_shift = shift_ff;
        if (conv_end)
            nxt_shift = {1'b0, result_in};
        else if (shift_now)
            nxt_shift = {shift_ff[30:0], 1'b1};
    end

    // Bit counter: falls in external mode, rises in internal mode
    always_comb
    begin
        nxt_bcnt = bcnt_ff;
        if (go_out_int)
            nxt_bcnt = BIT_FIRST;
        else if (go_out_ext | to_conv)
            nxt_bcnt = BIT_ZERO;
        else if (rise_now | (ext_mode_ff & shift_now))
            nxt_bcnt = bcnt_ff + BIT_FIRST;
    end

    // Device serial clock level; held high after a full frame
    always_comb
    begin
        nxt_sck_o = sck_o_ff;
        if (go_out_int | rise_now | end_int)
            nxt_sck_o = 1'b1;
        else if (shift_now & int_mode)
            nxt_sck_o = 1'b0;
        else if (cs_fall | conv_end)
            nxt_sck_o = 1'b0;
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    // Pin history and reset strap
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cs_q_ff <= 1'b1;
            sck_q_ff <= 1'b1;
            osc_q_ff <= 1'b0;
            por_done_ff <= 1'b0;
            ext_mode_ff <= 1'b0;
        end
        else
        begin
            cs_q_ff <= bus.cs_n;
            sck_q_ff <= bus.sck;
            osc_q_ff <= osc_source_pin;
            por_done_ff <= 1'b1;
            ext_mode_ff <= nxt_ext_mode;
        end
    end

    // Oscillator source detect; a silent pin falls back to internal
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            osc_ext_ff <= 1'b0;
            lost_ff <= '0;
            div_ff <= '0;
        end
        else
        begin
            div_ff <= div_wrap ? '0 : div_ff + 10'h001;
            if (osc_rise)
            begin
                osc_ext_ff <= 1'b1;
                lost_ff <= '0;
            end
            else if (lost_ff == OSC_LOST_LAST)
                osc_ext_ff <= 1'b0;
            else
                lost_ff <= lost_ff + 11'h001;
        end
    end

    // Cycle counters
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            conv_cnt_ff <= '0;
            dly_ff <= '0;
            half_ff <= '0;
        end
        else
        begin
            if (!in_conv)
                conv_cnt_ff <= '0;
            else if (tick)
                conv_cnt_ff <= conv_cnt_ff + 15'h0001;
            if (!dly_run)
                dly_ff <= '0;
            else if (dly_step)
                dly_ff <= dly_ff + 12'h001;
            if (!in_out)
                half_ff <= '0;
            else if (tick)
                half_ff <= half_ff + 2'h1;
        end
    end

    // Main state and shifter
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st_ff <= ASRP_CONV;
            shift_ff <= '0;
            bcnt_ff <= '0;
            sck_o_ff <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
            shift_ff <= nxt_shift;
            bcnt_ff <= nxt_bcnt;
            sck_o_ff <= nxt_sck_o;
        end
    end

    // Pin drivers; registered from the select pin in step with its sampled level
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            sdo_o_ff <= 1'b1;
            sdo_oe_n_ff <= 1'b1;
            sck_oe_n_ff <= 1'b1;
            sck_pu_ff <= 1'b1;
            busy_ff <= 1'b1;
            start_ff <= 1'b0;
        end
        else
        begin
            sdo_oe_n_ff <= bus.cs_n;
            sdo_o_ff <= (nxt_st == ASRP_CONV) | nxt_shift[31];
            sck_oe_n_ff <= bus.cs_n | nxt_ext_mode;
            sck_pu_ff <= pu_rearm | bus.sck;
            busy_ff <= nxt_st == ASRP_CONV;
            start_ff <= to_conv;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign bus.dev_sck_o = sck_o_ff;
    assign bus.dev_sck_oe_n = sck_oe_n_ff;
    assign bus.dev_sck_pu = sck_pu_ff;
    assign bus.dev_sdo_o = sdo_o_ff;
    assign bus.dev_sdo_oe_n = sdo_oe_n_ff;
    assign conv_busy = busy_ff;
    assign conv_start = start_ff;
endmodule : asrp_dev

// *** design/asrp_host.sv ***
// Host end: status test and 32-bit readout in either clock mode
`timescale 1ns/1ps
module asrp_host
    import asrp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    asrp_if.host bus,
    input wire logic start,
    input wire logic ext_mode,
    input wire logic status_only,
    output logic [31:0] frame,
    output logic frame_valid,
    output logic status_busy,
    output logic busy
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    asrp_hstate_t st_ff, nxt_st;
    logic mode_ff, sonly_ff, cs_ff, sck_ff, sck_oe_n_ff, sck_q_ff;
    logic [3:0] cnt_ff;
    logic [5:0] bits_ff;
    logic [31:0] frame_ff;
    logic valid_ff, stat_ff, busy_ff;

    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    wire in_wait = st_ff == ASRP_H_WAIT;
    wire in_clk = st_ff == ASRP_H_CLK;
    wire settled = in_wait & (cnt_ff == HOST_SETTLE_LAST);
    wire half_end = in_clk & mode_ff & (cnt_ff == HOST_HALF_LAST);
    // Sample on rises we make, or on rises the device makes
    wire sample = in_clk &
        (mode_ff ? half_end & ~sck_ff : ~sck_q_ff & bus.sck);
    wire ext_done = half_end & sck_ff & (bits_ff == FRAME_FULL);
    wire int_done = sample & ~mode_ff & (bits_ff == FRAME_LAST);

    always_comb
    begin
        nxt_st = st_ff;
        unique case (st_ff)
            ASRP_H_IDLE:
            begin
                if (start)
                    nxt_st = ASRP_H_WAIT;
            end
            ASRP_H_WAIT:
            begin
                // Status only returns select high before any rise
                if (settled & (sonly_ff | ~bus.sdo))
                    nxt_st = sonly_ff ? ASRP_H_DONE : ASRP_H_CLK;
            end
            ASRP_H_CLK:
            begin
                if (ext_done | int_done)
                    nxt_st = ASRP_H_DONE;
            end
            ASRP_H_DONE:
                nxt_st = ASRP_H_IDLE;
        endcase
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st_ff <= ASRP_H_IDLE;
            mode_ff <= 1'b0;
            sonly_ff <= 1'b0;
            cs_ff <= 1'b1;
            cnt_ff <= '0;
            sck_q_ff <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
            sck_q_ff <= bus.sck;
            if (st_ff == ASRP_H_IDLE)
            begin
                mode_ff <= ext_mode;
                sonly_ff <= status_only;
            end
            cs_ff <= (nxt_st == ASRP_H_IDLE) | (nxt_st == ASRP_H_DONE);
            if (nxt_st != st_ff | half_end | settled)
                cnt_ff <= '0;
            else
                cnt_ff <= cnt_ff + 4'h1;
        end
    end

    // Serial clock and data capture; clock held low for external mode
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            sck_ff <= 1'b0;
            // Drive the strap level in reset so the device latches it
            sck_oe_n_ff <= ~ext_mode;
            bits_ff <= '0;
            frame_ff <= '0;
        end
        else
        begin
            sck_oe_n_ff <= (st_ff == ASRP_H_IDLE) ? ~ext_mode
                                                  : ~mode_ff;
            if (half_end)
                sck_ff <= ~sck_ff;
            if (!in_clk)
                bits_ff <= '0;
            else if (sample)
                bits_ff <= bits_ff + BIT_FIRST;
            if (sample)
                frame_ff <= {frame_ff[30:0], bus.sdo};
        end
    end

    // User-side status
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            valid_ff <= 1'b0;
            stat_ff <= 1'b1;
            busy_ff <= 1'b0;
        end
        else
        begin
            valid_ff <= (st_ff == ASRP_H_DONE) & ~sonly_ff;
            if (settled)
                stat_ff <= bus.sdo;
            busy_ff <= nxt_st != ASRP_H_IDLE;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign bus.cs_n = cs_ff;
    assign bus.host_sck_o = sck_ff;
    assign bus.host_sck_oe_n = sck_oe_n_ff;
    assign frame = frame_ff;
    assign frame_valid = valid_ff;
    assign status_busy = stat_ff;
    assign busy = busy_ff;
endmodule : asrp_host

// *** dv/asrp_asserts.sv ***
// Concurrent checks on the link between converter port and host
`timescale 1ns/1ps
module asrp_asserts
    import asrp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic host_sck_oe_n,
    input wire logic dev_sck_o,
    input wire logic dev_sck_oe_n,
    input wire logic dev_sck_pu,
    input wire logic dev_sdo_o,
    input wire logic dev_sdo_oe_n,
    input wire logic sck,
    input wire logic sdo
);
    // ---------------------------------------------------------------
    // Helper counters
    // ---------------------------------------------------------------
    // Margin covers the two-flop sampling lag at select fall
    localparam int MIN_DLY = TEST_DLY_CYCLES - 8;
    logic sck_d_ff;
    logic [5:0] rise_cnt_ff;
    logic [11:0] low_cnt_ff;

    // Rises within one select period; a 33rd rise opens a new frame
    wire sck_rise = sck && !sck_d_ff;
    wire [5:0] nxt_rise_cnt = cs_n ? BIT_ZERO :
        !sck_rise ? rise_cnt_ff :
        (rise_cnt_ff == FRAME_FULL) ? BIT_FIRST : rise_cnt_ff + 6'h01;
    // Saturates so a long sleep never wraps to a short count
    wire [11:0] nxt_low_cnt = sck ? 12'h000 :
        (&low_cnt_ff) ? low_cnt_ff : low_cnt_ff + 12'h001;

    // Edge history and counters
    always_ff @(posedge clk)
    begin
        sck_d_ff <= resetn ? sck : 1'b1;
        rise_cnt_ff <= resetn ? nxt_rise_cnt : BIT_ZERO;
        low_cnt_ff <= resetn ? nxt_low_cnt : 12'h000;
    end

    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sdo_release_a: assert property (cs_n && $past(cs_n) |-> dev_sdo_oe_n)
        else $error("data line driven while deselected");
    sdo_enable_a: assert property ($fell(cs_n) |=> !dev_sdo_oe_n)
        else $error("data line not driven after select");
    pullup_off_a: assert property (
        !cs_n && !sck && !$past(sck) |-> !dev_sck_pu)
        else $error("pull-up left on with clock low");
    no_contention_a: assert property (!host_sck_oe_n |-> dev_sck_oe_n)
        else $error("device drives clock in external mode");
    ext_data_a: assert property (
        $changed(dev_sdo_o) && !dev_sdo_oe_n && !host_sck_oe_n |-> !sck)
        else $error("data changed while clock high");
    int_sck_low_a: assert property (
        $fell(cs_n) && host_sck_oe_n && sck
        |-> ##[1:3] (!dev_sck_oe_n && !dev_sck_o))
        else $error("internal clock not pulled low at select");
    restart_flag_a: assert property (
        !cs_n && rise_cnt_ff == FRAME_FULL && $changed(rise_cnt_ff)
        |-> ##[1:40] (sdo && !dev_sdo_oe_n))
        else $error("busy flag missing after frame");
    sck_hold_a: assert property (
        !cs_n && !dev_sck_oe_n && rise_cnt_ff == FRAME_FULL
        && $changed(rise_cnt_ff) |-> sck [*8])
        else $error("internal clock dropped after frame");
    test_delay_a: assert property (
        $rose(sck) && !dev_sck_oe_n && !cs_n
        && (rise_cnt_ff == BIT_ZERO || rise_cnt_ff == FRAME_FULL)
        |-> low_cnt_ff >= MIN_DLY)
        else $error("output began before status delay");
endmodule : asrp_asserts

// *** dv/tb_adc_serial_result_port.sv ***
// Self-checking bench: host and converter ends joined on one link
`timescale 1ns/1ps
module tb_adc_serial_result_port;
    // ---------------------------------------------------------------
    // Signals and instances
    // ---------------------------------------------------------------
    // Short conversion keeps the run small
    localparam int SIM_TICKS = 20;
    localparam int SIM_OSC = 4;
    localparam logic [30:0] VAL_A = 31'h5234_5678;
    localparam logic [30:0] VAL_B = 31'h2bcd_ef01;
    logic clk;
    logic resetn;
    logic start, ext_mode, status_only;
    logic [30:0] result_in;
    logic [31:0] frame, f;
    logic frame_valid, status_busy, hbusy, conv_busy, conv_busy2;
    int error_cnt = 0;
    int num_checks = 0;

    asrp_if bus_if();
    asrp_if bus2_if();

    asrp_dev #(.CONV_TICKS(SIM_TICKS), .INT_OSC_CYCLES(SIM_OSC)) i_asrp_dev (
        .clk(clk), .resetn(resetn), .bus(bus_if), .osc_source_pin(1'b0),
        .result_in(result_in), .conv_busy(conv_busy), .conv_start());
    asrp_host i_asrp_host (
        .clk(clk), .resetn(resetn), .bus(bus_if), .start(start),
        .ext_mode(ext_mode), .status_only(status_only), .frame(frame),
        .frame_valid(frame_valid), .status_busy(status_busy), .busy(hbusy));
    // Second converter faced by a bench driver that aborts a readout
    asrp_dev #(.CONV_TICKS(SIM_TICKS), .INT_OSC_CYCLES(SIM_OSC))
        i_asrp_dev_abort (
        .clk(clk), .resetn(resetn), .bus(bus2_if), .osc_source_pin(1'b0),
        .result_in(result_in), .conv_busy(conv_busy2), .conv_start());
    asrp_asserts i_asrp_asserts (
        .clk(clk), .resetn(resetn), .cs_n(bus_if.cs_n),
        .host_sck_oe_n(bus_if.host_sck_oe_n), .dev_sck_o(bus_if.dev_sck_o),
        .dev_sck_oe_n(bus_if.dev_sck_oe_n), .dev_sck_pu(bus_if.dev_sck_pu),
        .dev_sdo_o(bus_if.dev_sdo_o), .dev_sdo_oe_n(bus_if.dev_sdo_oe_n),
        .sck(bus_if.sck), .sdo(bus_if.sdo));

    // Free-running system clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    // Mode strap needs ext_mode settled well before release
    task automatic do_reset(input logic ext);
        resetn <= 1'b0;
        ext_mode <= ext;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
    endtask : do_reset

    // One host request; the frame is caught on its valid pulse
    task automatic run_host(input logic so);
        int i;
        @(posedge clk);
        start <= 1'b1;
        status_only <= so;
        @(posedge clk);
        start <= 1'b0;
        for (i = 0; i < 8000; i++)
        begin
            @(posedge clk);
            #1;
            if (frame_valid === 1'b1)
                f = frame;
            if (i > 2 && hbusy === 1'b0)
                break;
        end
        if (i == 8000)
        begin
            error_cnt++;
            conclude();
        end
    endtask : run_host

    // One external clock period on the abort link, sampled while high
    task automatic pulse2(input logic exp);
        bus2_if.host_sck_o <= 1'b1;
        repeat (8) @(posedge clk);
        #1 check(32'(bus2_if.sdo), 32'(exp));
        @(posedge clk);
        bus2_if.host_sck_o <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : pulse2

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        resetn = 1'b0;
        start = 1'b0;
        ext_mode = 1'b1;
        status_only = 1'b0;
        result_in = VAL_A;
        f = 32'h0;
        bus2_if.cs_n = 1'b1;
        bus2_if.host_sck_o = 1'b0;
        bus2_if.host_sck_oe_n = 1'b0;
        do_reset(1'b1);
        // Select blip mid-conversion must not restart it
        repeat (20) @(posedge clk);
        bus2_if.cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1 check(32'(bus2_if.sdo), 32'h1);
        @(posedge clk);
        bus2_if.cs_n <= 1'b1;
        repeat (30) @(posedge clk);
        #1 check(32'(conv_busy2), 32'h1);
        repeat (45) @(posedge clk);
        #1 check(32'(conv_busy2), 32'h0);
        // Partial readout then abort by select rise
        @(posedge clk);
        bus2_if.cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        #1 check(32'(bus2_if.sdo), 32'h0);
        @(posedge clk);
        pulse2(1'b0);
        pulse2(VAL_A[30]);
        pulse2(VAL_A[29]);
        bus2_if.cs_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check(32'(conv_busy2), 32'h1);
        check(32'(bus2_if.dev_sdo_oe_n), 32'h1);
        // External clock: status test, held result, back-to-back reads
        check(32'(conv_busy), 32'h0);
        result_in <= VAL_B;
        run_host(1'b1);
        check(32'(status_busy), 32'h0);
        check(32'(conv_busy), 32'h0);
        run_host(1'b0);
        check(f, {1'b0, VAL_A});
        repeat (20) @(posedge clk);
        #1 check(32'(conv_busy), 32'h1);
        run_host(1'b1);
        check(32'(status_busy), 32'h1);
        run_host(1'b0);
        check(f, {1'b0, VAL_B});
        // Internal clock: status test leaves it asleep, then full read
        @(posedge clk);
        do_reset(1'b0);
        result_in <= VAL_A;
        repeat (100) @(posedge clk);
        result_in <= VAL_B;
        run_host(1'b1);
        check(32'(status_busy), 32'h0);
        repeat (3000) @(posedge clk);
        #1 check(32'(conv_busy), 32'h0);
        run_host(1'b0);
        check(f, {1'b0, VAL_A});
        repeat (20) @(posedge clk);
        #1 check(32'(conv_busy), 32'h1);
        conclude();
    end
endmodule : tb_adc_serial_result_port
